// File: rtl/pcd_clock_ctrl.sv
// What this block does
// - Ratio low bit zero: divide core clock by 8, 9, 10, 11.
// - Ratio low bit one: divide core clock by 4, 4.5, 5, 5.5.
// - Output rate from captured straps, or from software-written field.
// - Low bit of ratio field resets to zero.
// - Each of six PCI clock outputs has its own enable bit.
// - PCI controller clock comes from the feedback input pin.
// - Internal controller clock follows feedback in frequency and phase.
// - One serial clock input feeds both serial ports.
// - One timer clock input feeds all three timers.
// - Audio bit clock shares gp line 2 pin, strap picks function.
// - Upper two ratio bits load from straps sampled after reset release, once the filter has settled.
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`default_nettype none

module pcd_clock_ctrl
    import pcd_pkg::*;
(
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_clk_en,
    input  wire pcd_wb_req_t                i_wb_req,
    output pcd_wb_rsp_t                     o_wb_rsp,
    input  wire logic [1:0]                 i_ratio_strap,
    input  wire logic                       i_audio_strap,
    input  wire logic                       i_pci_clk_feedback_in,
    input  wire logic                       i_serial_ext_clk,
    input  wire logic                       i_timer_ext_clk,
    input  wire logic                       i_shared_clk_pin,
    output logic [PCD_NUM_PCI_OUT-1:0]      o_pci_clk_out,
    output logic                            o_pci_ctrl_internal_clk,
    output logic                            o_serial_port_a_clk,
    output logic                            o_serial_port_b_clk,
    output logic                            o_timer_a_clk,
    output logic                            o_timer_b_clk,
    output logic                            o_timer_c_clk,
    output logic                            o_audio_link_bit_clk,
    output logic                            o_gp_io_line2_in
);

    logic [PCD_PIN_W-1:0]        pins_s;
    logic [2:0]                  settle_q;
    logic                        strap_done_q;
    logic                        audio_mode_q;
    logic [PCD_RATIO_W-1:0]      pci_ratio_sel_q;
    logic [PCD_NUM_PCI_OUT-1:0]  pci_out_gate_en_q;
    pcd_wb_rsp_t                 wb_rsp_q;
    logic                        wb_hit;
    logic                        wr_chip;
    logic                        wr_pin;
    logic [PCD_DAT_W-1:0]        rd_data;

    logic [PCD_RATIO_W-1:0]      ratio_act_q;
    logic                        alt_q;
    logic [3:0]                  cnt_q;
    logic                        gen_q;
    logic [4:0]                  ratio2;
    logic [3:0]                  per_len;
    logic [3:0]                  high_len;
    logic [PCD_NUM_PCI_OUT-1:0]  gate_q;
    logic [PCD_NUM_PCI_OUT-1:0]  pci_out_q;

    logic                        fb_q;
    logic                        ser_a_q;
    logic                        ser_b_q;
    logic                        tmr_a_q;
    logic                        tmr_b_q;
    logic                        tmr_c_q;
    logic                        audio_clk_q;
    logic                        gp_line2_q;

    // Every off-chip level passes the three-stage filter
    pcd_sync3 #(
        .W (PCD_PIN_W)
    ) u_pin_sync (
        .i_clk   (i_sys_clk),
        .i_rst_n (i_rst_n),
        .i_en    (i_clk_en),
        .i_async ({i_shared_clk_pin, i_timer_ext_clk, i_serial_ext_clk,
                   i_pci_clk_feedback_in, i_audio_strap, i_ratio_strap}),
        .o_sync  (pins_s)
    );

    // Straps are taken once the filter has settled after release
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            settle_q     <= 3'h0;
            strap_done_q <= 1'b0;
        end else if (i_clk_en && !strap_done_q) begin
            if (settle_q == PCD_STRAP_SETTLE) begin
                strap_done_q <= 1'b1;
            end else begin
                settle_q <= settle_q + 3'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            audio_mode_q <= 1'b0;
        end else if (i_clk_en && !strap_done_q
                     && settle_q == PCD_STRAP_SETTLE) begin
            audio_mode_q <= pins_s[PCD_PIN_AUDSEL];
        end
    end

    // Wishbone classic slave: one wait state, unmapped reads give zero
    assign wb_hit  = i_wb_req.cyc && i_wb_req.stb && !wb_rsp_q.ack;
    assign wr_chip = wb_hit && i_wb_req.we && i_wb_req.sel[0]
                     && i_wb_req.adr == PCD_OFS_CHIP_CFG;
    assign wr_pin  = wb_hit && i_wb_req.we && i_wb_req.sel[0]
                     && i_wb_req.adr == PCD_OFS_PIN_CFG;

    always_comb begin
        rd_data = '0;
        case (i_wb_req.adr)
            PCD_OFS_CHIP_CFG: begin
                rd_data[PCD_RATIO_LSB +: PCD_RATIO_W] = pci_ratio_sel_q;
                rd_data[PCD_AUDIO_BIT]                = audio_mode_q;
            end
            PCD_OFS_PIN_CFG: begin
                rd_data[PCD_NUM_PCI_OUT-1:0] = pci_out_gate_en_q;
            end
            PCD_OFS_STATUS: begin
                rd_data[PCD_RATIO_W-1:0]  = ratio_act_q;
                rd_data[PCD_STAT_GEN_BIT] = gen_q;
            end
            default: begin
                rd_data = '0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wb_rsp_q <= '0;
        end else if (i_clk_en) begin
            wb_rsp_q.ack <= wb_hit;
            if (wb_hit && !i_wb_req.we) begin
                wb_rsp_q.dat <= rd_data;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pci_ratio_sel_q <= PCD_RATIO_RST;
        end else if (i_clk_en) begin
            if (wr_chip) begin
                pci_ratio_sel_q <=
                    i_wb_req.dat[PCD_RATIO_LSB +: PCD_RATIO_W];
            end else if (!strap_done_q
                         && settle_q == PCD_STRAP_SETTLE) begin
                pci_ratio_sel_q[2:1] <= pins_s[PCD_PIN_STRAP2:
                                               PCD_PIN_STRAP1];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pci_out_gate_en_q <= PCD_GATE_RST;
        end else if (i_clk_en && wr_pin) begin
            pci_out_gate_en_q <= i_wb_req.dat[PCD_NUM_PCI_OUT-1:0];
        end
    end

    always_comb begin
        ratio2 = PCD_RATIO_BASE + {3'h0, ratio_act_q[2:1]};
        if (!ratio_act_q[0]) begin
            ratio2 = {ratio2[3:0], 1'b0};
        end
    end

    // odd half-count alternates short and long periods
    always_comb begin
        per_len = ratio2[4:1];
        if (ratio2[0] && alt_q) begin
            per_len = ratio2[4:1] + 4'h1;
        end
        high_len = {1'b0, per_len[3:1]};
    end

    // New ratio is adopted only at a period boundary
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q       <= 4'h0;
            alt_q       <= 1'b0;
            ratio_act_q <= PCD_RATIO_RST;
            gen_q       <= 1'b0;
        end else if (i_clk_en) begin
            gen_q <= cnt_q < high_len;
            if (cnt_q >= per_len - 4'h1) begin
                cnt_q       <= 4'h0;
                alt_q       <= !alt_q;
                ratio_act_q <= pci_ratio_sel_q;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // gate moves only while the generated clock is low
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gate_q <= '0;
        end else if (i_clk_en && !gen_q) begin
            gate_q <= pci_out_gate_en_q;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pci_out_q <= '0;
        end else if (i_clk_en) begin
            pci_out_q <= gate_q & {PCD_NUM_PCI_OUT{gen_q}};
        end
    end

    // controller clock tracks the feedback pin
    // Fixed latency of the filter plus the fb_q register is the only phase offset
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fb_q <= 1'b0;
        end else if (i_clk_en) begin
            fb_q <= pins_s[PCD_PIN_FB];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ser_a_q <= 1'b0;
            ser_b_q <= 1'b0;
            tmr_a_q <= 1'b0;
            tmr_b_q <= 1'b0;
            tmr_c_q <= 1'b0;
        end else if (i_clk_en) begin
            ser_a_q <= pins_s[PCD_PIN_SER];
            ser_b_q <= pins_s[PCD_PIN_SER];
            tmr_a_q <= pins_s[PCD_PIN_TMR];
            tmr_b_q <= pins_s[PCD_PIN_TMR];
            tmr_c_q <= pins_s[PCD_PIN_TMR];
        end
    end

    // shared pin steered by the captured strap
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            audio_clk_q <= 1'b0;
            gp_line2_q  <= 1'b0;
        end else if (i_clk_en) begin
            audio_clk_q <= audio_mode_q && pins_s[PCD_PIN_SHARED];
            gp_line2_q  <= !audio_mode_q && pins_s[PCD_PIN_SHARED];
        end
    end

    assign o_wb_rsp                = wb_rsp_q;
    assign o_pci_clk_out           = pci_out_q;
    assign o_pci_ctrl_internal_clk = fb_q;
    assign o_serial_port_a_clk     = ser_a_q;
    assign o_serial_port_b_clk     = ser_b_q;
    assign o_timer_a_clk           = tmr_a_q;
    assign o_timer_b_clk           = tmr_b_q;
    assign o_timer_c_clk           = tmr_c_q;
    assign o_audio_link_bit_clk    = audio_clk_q;
    assign o_gp_io_line2_in        = gp_line2_q;

    // Helper: rising-edge period measurement of the generated clock
    logic                   gen_prev_q;
    logic                   gen_rise;
    logic [4:0]             per_cnt_q;
    logic [4:0]             last_per_q;
    logic [1:0]             rises_q;
    logic [PCD_RATIO_W-1:0] ratio_at_rise_q;

    assign gen_rise = gen_q && !gen_prev_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gen_prev_q      <= 1'b0;
            per_cnt_q       <= 5'h00;
            last_per_q      <= 5'h00;
            rises_q         <= 2'h0;
            ratio_at_rise_q <= PCD_RATIO_RST;
        end else if (i_clk_en) begin
            gen_prev_q <= gen_q;
            if (gen_rise) begin
                per_cnt_q       <= 5'h01;
                last_per_q      <= per_cnt_q;
                ratio_at_rise_q <= ratio_act_q;
                if (ratio_at_rise_q != ratio_act_q) begin
                    rises_q <= 2'h0;
                end else if (rises_q != 2'h3) begin
                    rises_q <= rises_q + 2'h1;
                end
            end else begin
                per_cnt_q <= per_cnt_q + 5'h01;
            end
        end
    end

    chk_int_period: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && gen_rise && rises_q == 2'h3 && !ratio2[0]
         && ratio_at_rise_q == ratio_act_q)
        |-> per_cnt_q == {1'b0, ratio2[4:1]})
        else $error("integer divide period wrong");

    // half ratio: two periods sum to twice the ratio
    chk_half_period: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && gen_rise && rises_q == 2'h3 && ratio2[0]
         && ratio_at_rise_q == ratio_act_q)
        |-> per_cnt_q + last_per_q == ratio2
            && per_cnt_q != last_per_q)
        else $error("half divide periods wrong");

    // strap capture leaves low bit zero
    chk_strap_load: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        $rose(strap_done_q) && !$past(wr_chip)
        |-> pci_ratio_sel_q[0] == 1'b0
            && pci_ratio_sel_q[2:1] == $past(pins_s[1:0]))
        else $error("ratio field not loaded from straps");

    // software write replaces the ratio field
    chk_sw_ratio: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && wr_chip)
        |=> pci_ratio_sel_q == $past(i_wb_req.dat[2:0]))
        else $error("ratio write not taken");

    // gate changes only after a low generated phase
    chk_gate_low_phase: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        $changed(gate_q) |-> !$past(gen_q))
        else $error("gate changed during high phase");

    // an output disabled for two cycles stays low
    chk_out_disabled: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (!pci_out_gate_en_q[0] && !gate_q[0]) ##1 !gate_q[0]
        |-> !pci_out_q[0])
        else $error("disabled output toggled");

    // controller clock follows the filtered pin
    chk_fb_follow: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en |=> o_pci_ctrl_internal_clk == $past(pins_s[3]))
        else $error("controller clock lost the feedback");

    chk_fanout_equal: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        o_serial_port_a_clk == o_serial_port_b_clk
        && o_timer_a_clk == o_timer_b_clk
        && o_timer_b_clk == o_timer_c_clk)
        else $error("shared clock copies differ");

    // shared pin drives only one function
    chk_audio_excl: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        !(o_audio_link_bit_clk && o_gp_io_line2_in))
        else $error("shared pin drives both functions");

    chk_wb_ack_once: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        (i_clk_en && wb_hit) |=> o_wb_rsp.ack ##1 (!i_clk_en
            || !o_wb_rsp.ack))
        else $error("ack not a single pulse");

endmodule // pcd_clock_ctrl

`default_nettype wire

// File: rtl/pcd_pkg.sv
`default_nettype none

package pcd_pkg;

    // Classic Wishbone slave geometry
    localparam int unsigned PCD_ADR_W = 8;
    localparam int unsigned PCD_DAT_W = 32;
    localparam int unsigned PCD_SEL_W = 4;

    // Register byte offsets
    localparam logic [7:0] PCD_OFS_CHIP_CFG = 8'h00;
    localparam logic [7:0] PCD_OFS_PIN_CFG  = 8'h04;
    localparam logic [7:0] PCD_OFS_STATUS   = 8'h08;

    // chip_cfg_reg fields
    localparam int unsigned PCD_RATIO_LSB   = 0;
    localparam int unsigned PCD_RATIO_W     = 3;
    localparam int unsigned PCD_AUDIO_BIT   = 3;
    localparam logic [2:0]  PCD_RATIO_RST   = 3'h0;

    // pin_cfg_reg fields
    localparam int unsigned PCD_NUM_PCI_OUT = 6;
    localparam logic [5:0]  PCD_GATE_RST    = 6'h3F;

    // status register fields
    localparam int unsigned PCD_STAT_GEN_BIT = 3;

    // Divide ratio in half core cycles is base plus ratio_sel[2:1],
    // doubled when ratio_sel[0] is zero
    localparam logic [4:0] PCD_RATIO_BASE = 5'h08;

    // Synchroniser pin slots
    localparam int unsigned PCD_PIN_W      = 7;
    localparam int unsigned PCD_PIN_STRAP1 = 0;
    localparam int unsigned PCD_PIN_STRAP2 = 1;
    localparam int unsigned PCD_PIN_AUDSEL = 2;
    localparam int unsigned PCD_PIN_FB     = 3;
    localparam int unsigned PCD_PIN_SER    = 4;
    localparam int unsigned PCD_PIN_TMR    = 5;
    localparam int unsigned PCD_PIN_SHARED = 6;

    // Cycles after reset release before straps are taken
    localparam logic [2:0] PCD_STRAP_SETTLE = 3'h4;

    typedef struct packed {
        logic                 cyc;
        logic                 stb;
        logic                 we;
        logic [PCD_ADR_W-1:0] adr;
        logic [PCD_SEL_W-1:0] sel;
        logic [PCD_DAT_W-1:0] dat;
    } pcd_wb_req_t;

    typedef struct packed {
        logic                 ack;
        logic [PCD_DAT_W-1:0] dat;
    } pcd_wb_rsp_t;

endpackage

`default_nettype wire

// File: rtl/pcd_sync3.sv
`default_nettype none

module pcd_sync3 #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_en,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    // First stage is read by the second stage only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (i_en) begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_q <= '0;
        end else if (i_en) begin
            out_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
        end
    end

    assign o_sync = out_q;

endmodule // pcd_sync3

`default_nettype wire

// File: bench/pcd_board_model.sv
`default_nettype none

module pcd_board_model #(
    parameter int unsigned TRACE_NS = 2
) (
    input  wire logic i_pci_clk,
    output logic      o_feedback
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_feedback = 1'b0;
    end

    // board loops clock
    // Trace delay shifts phase, so the receiver must track, not copy
    always @(i_pci_clk) begin
        o_feedback <= #(TRACE_NS) i_pci_clk;
    end

endmodule // pcd_board_model

`default_nettype wire

// File: bench/testbench.sv
`default_nettype none

module testbench
    import pcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic [2:0] ratio;
        int         two_per;
    } pcd_row_t;

    logic        sys_clk;
    logic        rst_n;
    logic        clk_en;
    pcd_wb_req_t req;
    pcd_wb_rsp_t rsp;
    logic [1:0]  strap;
    logic        audio_strap;
    logic        fb;
    logic        ser_clk;
    logic        tmr_clk;
    logic        shared_pin;
    logic [5:0]  pci_out;
    logic [5:0]  hold;
    logic        ctrl_clk;
    logic        ser_a;
    logic        ser_b;
    logic        tm_a;
    logic        tm_b;
    logic        tm_c;
    logic        aud_clk;
    logic        gp2;
    logic        seen5;
    logic        seen4;
    logic [31:0] rd;
    int          err_total;
    int          cmp_count;
    int          cyc_cnt;
    int          cyc;

    // Two periods in core cycles, so half ratios come out whole
    // rows 011 and 010 give the 66 and 33 MHz settings
    pcd_row_t rows [8] = '{'{3'h0, 16}, '{3'h1, 8}, '{3'h2, 18},
        '{3'h3, 9}, '{3'h4, 20}, '{3'h5, 10}, '{3'h6, 22}, '{3'h7, 11}};

    pcd_clock_ctrl u_dut (
        .i_sys_clk               (sys_clk),
        .i_rst_n                 (rst_n),
        .i_clk_en                (clk_en),
        .i_wb_req                (req),
        .o_wb_rsp                (rsp),
        .i_ratio_strap           (strap),
        .i_audio_strap           (audio_strap),
        .i_pci_clk_feedback_in   (fb),
        .i_serial_ext_clk        (ser_clk),
        .i_timer_ext_clk         (tmr_clk),
        .i_shared_clk_pin        (shared_pin),
        .o_pci_clk_out           (pci_out),
        .o_pci_ctrl_internal_clk (ctrl_clk),
        .o_serial_port_a_clk     (ser_a),
        .o_serial_port_b_clk     (ser_b),
        .o_timer_a_clk           (tm_a),
        .o_timer_b_clk           (tm_b),
        .o_timer_c_clk           (tm_c),
        .o_audio_link_bit_clk    (aud_clk),
        .o_gp_io_line2_in        (gp2)
    );

    pcd_board_model u_board (
        .i_pci_clk  (pci_out[0]),
        .o_feedback (fb)
    );

    task automatic print_verdict();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [3:0] sel, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge sys_clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
        do begin
            @(posedge sys_clk);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        rd = rsp.dat;
        check("wb_ack", {31'h0, rsp.ack}, 32'h0000_0001);
        req <= '0;
    endtask

    task automatic measure(input bit internal, output int cnt);
        int   edges;
        int   n;
        logic p;
        logic c;
        edges = 0;
        n = 0;
        cnt = 0;
        p = internal ? ctrl_clk : pci_out[0];
        while (edges < 3 && n < 300) begin
            @(posedge sys_clk);
            #1;
            c = internal ? ctrl_clk : pci_out[0];
            n++;
            if (edges > 0) cnt++;
            if (c && !p) edges++;
            p = c;
        end
    endtask

    task automatic watch_gates();
        seen5 = 1'b0;
        seen4 = 1'b0;
        repeat (40) begin
            @(posedge sys_clk);
            #1;
            seen5 |= pci_out[5];
            seen4 |= pci_out[4];
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Hang guard, run needs about a thousand cycles
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        req = '0;
        strap = 2'b10;
        audio_strap = 1'b1;
        ser_clk = 1'b0;
        tmr_clk = 1'b0;
        shared_pin = 1'b0;
        err_total = 0;
        cmp_count = 0;
        cyc_cnt = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
        wb_cycle(1'b0, PCD_OFS_CHIP_CFG, 4'hF, '0);
        check("chip_cfg", rd, 32'h0000_000C);
        wb_cycle(1'b0, PCD_OFS_PIN_CFG, 4'hF, '0);
        check("pin_cfg", rd, 32'h0000_003F);
        wb_cycle(1'b0, 8'h0C, 4'hF, '0);
        check("unmapped", rd, 32'h0000_0000);
        measure(1'b0, cyc);
        check("strap_period", cyc, 20);
        foreach (rows[i]) begin
            wb_cycle(1'b1, PCD_OFS_CHIP_CFG, 4'hF, {29'h0, rows[i].ratio});
            repeat (30) @(posedge sys_clk);
            measure(1'b0, cyc);
            check("pci_period", cyc, rows[i].two_per);
            measure(1'b1, cyc);
            check("ctrl_period", cyc, rows[i].two_per);
            wb_cycle(1'b0, PCD_OFS_STATUS, 4'hF, '0);
            check("status", {29'h0, rd[2:0]}, {29'h0, rows[i].ratio});
        end
        wb_cycle(1'b1, PCD_OFS_CHIP_CFG, 4'hE, 32'h0000_0001);
        wb_cycle(1'b0, PCD_OFS_CHIP_CFG, 4'hF, '0);
        check("lane_ignored", {29'h0, rd[2:0]}, 32'h0000_0007);
        clk_en <= 1'b0;
        @(posedge sys_clk);
        #1;
        hold = pci_out;
        repeat (20) @(posedge sys_clk);
        check("frozen", {26'h0, pci_out}, {26'h0, hold});
        clk_en <= 1'b1;
        // per-output gating
        // Bit 0 off too, so the disabled-output assertion is exercised
        wb_cycle(1'b1, PCD_OFS_PIN_CFG, 4'hF, 32'h0000_001E);
        repeat (30) @(posedge sys_clk);
        watch_gates();
        check("gated", {30'h0, seen5, seen4}, 32'h0000_0001);
        wb_cycle(1'b1, PCD_OFS_PIN_CFG, 4'hF, 32'h0000_003F);
        repeat (30) @(posedge sys_clk);
        watch_gates();
        check("ungated", {30'h0, seen5, seen4}, 32'h0000_0003);
        for (int v = 1; v >= 0; v--) begin
            ser_clk <= v[0];
            tmr_clk <= v[0];
            shared_pin <= v[0];
            repeat (8) @(posedge sys_clk);
            #1;
            check("serial", {30'h0, ser_a, ser_b}, {30'h0, v[0], v[0]});
            check("timer", {29'h0, tm_a, tm_b, tm_c}, {29'h0, {3{v[0]}}});
            check("audio", {30'h0, aud_clk, gp2}, {30'h0, v[0], 1'b0});
        end
        // Second reset with other straps
        rst_n <= 1'b0;
        #1;
        check("reset_out", {26'h0, pci_out}, 32'h0000_0000);
        strap = 2'b01;
        audio_strap = 1'b0;
        shared_pin = 1'b1;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
        wb_cycle(1'b0, PCD_OFS_CHIP_CFG, 4'hF, '0);
        check("chip_cfg2", rd, 32'h0000_0002);
        check("gp_line", {30'h0, aud_clk, gp2}, 32'h0000_0001);
        measure(1'b0, cyc);
        check("strap_period2", cyc, 18);
        print_verdict();
    end

endmodule // testbench

`default_nettype wire
